// ==== logic/fcb_pkg.sv ====
// shared constants, types and helpers for the conditional branch unit
package fcb_pkg;
	// widths of the program counter, instruction word and offset
	localparam int PC_W = 21;
	localparam int WORD_W = 16;
	localparam int OFF_W = 8;
	localparam int SEXT_W = PC_W - OFF_W;
	// upper byte opcodes of the two branches
	localparam logic [7:0] OP_CARRY_CLEAR = 8'he3;
	localparam logic [7:0] OP_SIGN_CLEAR = 8'he7;
	// field positions inside the instruction word
	localparam int OPC_HI = 15;
	localparam int OPC_LO = 8;
	localparam int OFF_HI = 7;
	localparam int OFF_LO = 0;
	// bytes that the counter advances past one instruction word
	localparam logic [PC_W-1:0] INSTR_BYTES = 21'h000002;
	// phase numbers inside one instruction cycle
	localparam logic [1:0] PH_Q1 = 2'h0;
	localparam logic [1:0] PH_Q2 = 2'h1;
	localparam logic [1:0] PH_Q3 = 2'h2;
	localparam logic [1:0] PH_Q4 = 2'h3;
	// reset values
	localparam logic [PC_W-1:0] PC_RST = 21'h000000;
	localparam logic [OFF_W-1:0] OFF_RST = 8'h00;
	localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

	// sequencer states
	typedef enum logic [1:0] {
		FCB_IDLE = 2'b00,
		FCB_EXEC = 2'b01,
		FCB_NOP = 2'b10
	} fcb_state_type;

	// sign extension of the offset byte to counter width
	function automatic logic [PC_W-1:0] fcb_sext(input logic [OFF_W-1:0] n);
		return {{SEXT_W{n[OFF_W-1]}}, n};
	endfunction

	// counter after the branch word plus twice the offset
	function automatic logic [PC_W-1:0] fcb_target(
		input logic [PC_W-1:0] addr,
		input logic [OFF_W-1:0] n
	);
		logic [PC_W-1:0] ext;
		ext = fcb_sext(n);
		return addr + INSTR_BYTES + {ext[PC_W-2:0], 1'b0};
	endfunction
endpackage

// ==== logic/fcb_dec_if.sv ====
// carrier between the sequencer and the opcode decoder
`timescale 1ns/100ps
interface fcb_dec_if;
	logic [fcb_pkg::WORD_W-1:0] word; // latched instruction word
	logic is_carry_br; // word is branch on carry clear
	logic is_sign_br; // word is branch on negative clear
	logic [fcb_pkg::OFF_W-1:0] offset; // raw low byte
	modport dec (
		input word,
		output is_carry_br,
		output is_sign_br,
		output offset
	);
	modport seq (
		output word,
		input is_carry_br,
		input is_sign_br,
		input offset
	);
endinterface

// ==== logic/fcb_decode.sv ====
// opcode decoder for the two flag-conditional branches
`timescale 1ns/100ps
module fcb_decode (
	// decode carrier
	fcb_dec_if.dec dec
);
	import fcb_pkg::*;

	// pure decode, no state: the sequencer chooses when to look
	always_comb begin
		dec.is_carry_br = (dec.word[OPC_HI:OPC_LO] == OP_CARRY_CLEAR);
		dec.is_sign_br = (dec.word[OPC_HI:OPC_LO] == OP_SIGN_CLEAR);
		dec.offset = dec.word[OFF_HI:OFF_LO];
	end
endmodule

// ==== logic/fcb_exec.sv ====
// sequencer that executes branch on carry clear and on negative clear
// Overview of operation
// - opcode e3 branches when carry is zero
// - opcode e7 branches when negative is zero
// - low byte is sign-extended signed offset
// - taken branch adds twice offset to counter
// - target is own address plus two plus 2n
// - taken costs two cycles, untaken one
`timescale 1ns/100ps
module fcb_exec (
	// clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// instruction hand-off from fetch
	input wire logic start_i,
	input wire logic [fcb_pkg::WORD_W-1:0] word_i,
	input wire logic [fcb_pkg::PC_W-1:0] addr_i,
	output logic ready_o,
	// status flags from the core
	input wire logic carry_i,
	input wire logic negative_i,
	// program counter update
	output logic pc_wr_o,
	output logic [fcb_pkg::PC_W-1:0] pc_target_o,
	// progress
	output logic [1:0] phase_o,
	output logic nop_o,
	output logic done_o
);
	import fcb_pkg::*;

	// one clock edge is one phase and four phases make one cycle;
	// the flags are looked at once, in Q1, so the instruction before
	// must have settled them by the end of Q1, one phase after start_i is seen
	// pc_target_o moves on every instruction, untaken ones too:
	// cheaper than gating it, but only pc_wr_o marks a real jump

	// sequencing registers
	fcb_state_type state; // sequencer state
	fcb_state_type next_state;
	logic [1:0] q; // current phase
	logic [1:0] next_q;
	// per-instruction datapath registers
	logic [WORD_W-1:0] word_q; // held instruction word
	logic [WORD_W-1:0] next_word_q;
	logic [PC_W-1:0] addr_q; // address of the branch word
	logic [PC_W-1:0] next_addr_q;
	logic taken; // condition met, decided in Q1
	logic next_taken;
	logic [OFF_W-1:0] off_q; // offset read in Q2
	logic [OFF_W-1:0] next_off_q;
	logic [PC_W-1:0] target; // target computed in Q3
	logic [PC_W-1:0] next_target;
	logic pc_wr; // counter write strobe, Q4 only
	logic next_pc_wr;

	fcb_dec_if dbus ();

	// decoder sees the held word so fetch may move on
	fcb_decode u_dec (
		.dec(dbus.dec)
	);
	assign dbus.word = word_q;

	// handshake outputs are combinational, data from flops
	assign ready_o = (state == FCB_IDLE);
	assign done_o = (q == PH_Q4) &&
		((state == FCB_NOP) || ((state == FCB_EXEC) && !taken));
	assign pc_wr_o = pc_wr;
	assign pc_target_o = target;
	assign phase_o = q;
	assign nop_o = (state == FCB_NOP);
	// no flag output exists: these branches never touch status

	// next-state and datapath computation
	always_comb begin
		next_state = state;
		next_q = q;
		next_word_q = word_q;
		next_addr_q = addr_q;
		next_taken = taken;
		next_off_q = off_q;
		next_target = target;
		next_pc_wr = 1'b0;
		case (state)
			FCB_IDLE: begin
				// accept a word only between instructions
				if (start_i) begin
					next_state = FCB_EXEC;
					next_q = PH_Q1;
					next_word_q = word_i;
					next_addr_q = addr_i;
				end
			end
			FCB_EXEC: begin
				next_q = q + 2'h1;
				case (q)
					PH_Q1: begin
						// decode; flags sampled here, a later change is ignored
						next_taken = (dbus.is_carry_br && !carry_i) ||
							(dbus.is_sign_br && !negative_i);
					end
					PH_Q2: begin
						next_off_q = dbus.offset;
					end
					PH_Q3: begin
						// counter past the word plus sign-extended 2n
						next_target = fcb_target(addr_q, off_q);
						next_pc_wr = taken;
					end
					PH_Q4: begin
						// taken branch adds a dead cycle
						next_state = taken ? FCB_NOP : FCB_IDLE;
					end
					default: begin
						next_q = PH_Q1;
					end
				endcase
			end
			FCB_NOP: begin
				// four idle phases while fetch refills
				next_q = q + 2'h1;
				if (q == PH_Q4) begin
					next_state = FCB_IDLE;
				end
			end
			default: begin
				next_state = FCB_IDLE;
				next_q = PH_Q1;
			end
		endcase
	end

	// registers only
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= FCB_IDLE;
			q <= PH_Q1;
			word_q <= WORD_RST;
			addr_q <= PC_RST;
			taken <= 1'b0;
			off_q <= OFF_RST;
			target <= PC_RST;
			pc_wr <= 1'b0;
		end else begin
			state <= next_state;
			q <= next_q;
			word_q <= next_word_q;
			addr_q <= next_addr_q;
			taken <= next_taken;
			off_q <= next_off_q;
			target <= next_target;
			pc_wr <= next_pc_wr;
		end
	end

	// checks, all on the core clock and quiet while reset is low;
	// the four condition checks start from the Q1 decode so that one attempt follows one
	// instruction from decode to its last phase
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	// condition decode
	a_carry_clear_jump: assert property (
		(state == FCB_EXEC && q == PH_Q1 && dbus.is_carry_br && !carry_i)
		|-> ##3 pc_wr_o)
		else $error("carry clear branch did not write counter");
	a_carry_set_stay: assert property (
		(state == FCB_EXEC && q == PH_Q1 && dbus.is_carry_br && carry_i)
		|-> ##3 !pc_wr_o ##1 (state == FCB_IDLE))
		else $error("carry set branch was taken");
	a_sign_clear_jump: assert property (
		(state == FCB_EXEC && q == PH_Q1 && dbus.is_sign_br && !negative_i)
		|-> ##3 pc_wr_o)
		else $error("negative clear branch did not write counter");
	a_sign_set_stay: assert property (
		(state == FCB_EXEC && q == PH_Q1 && dbus.is_sign_br && negative_i)
		|-> ##3 !pc_wr_o ##1 (state == FCB_IDLE))
		else $error("negative set branch was taken");

	// target arithmetic, worked out apart from the adder function
	a_offset_sign_ext: assert property (
		pc_wr_o && off_q[OFF_W-1]
		|-> (addr_q + INSTR_BYTES - pc_target_o) ==
			(({{SEXT_W{1'b0}}, ~off_q}) + 21'h000001) * 21'h000002)
		else $error("negative offset not sign-extended");
	a_word_aligned: assert property (
		pc_wr_o |-> (pc_target_o[0] == addr_q[0]) &&
			((pc_target_o - addr_q) == (INSTR_BYTES +
			{{(SEXT_W-1){off_q[OFF_W-1]}}, off_q, 1'b0})))
		else $error("displacement not twice the offset");
	a_zero_offset_next: assert property (
		pc_wr_o && off_q == OFF_RST |-> pc_target_o == addr_q + INSTR_BYTES)
		else $error("zero offset target not next word");

	// cycle counts and refusal while busy
	a_taken_nop_cycle: assert property (
		pc_wr_o |=> nop_o [*4] ##1 ready_o)
		else $error("taken branch lacks one no-op cycle");
	a_untaken_one_cycle: assert property (
		(ready_o && start_i) ##1 (q == PH_Q1 && !dbus.is_carry_br &&
			!dbus.is_sign_br) |-> ##3 done_o ##1 ready_o)
		else $error("untaken instruction exceeds one cycle");
	a_write_in_q4: assert property (
		pc_wr_o |-> state == FCB_EXEC && $past(q) == PH_Q3)
		else $error("counter write outside fourth phase");
	a_busy_word_held: assert property (
		!ready_o |=> $stable(word_q) && $stable(addr_q))
		else $error("instruction replaced while busy");
	a_done_then_ready: assert property (
		done_o |=> !done_o && ready_o)
		else $error("done not followed by idle");
	a_nop_no_write: assert property (
		nop_o |-> !pc_wr_o && !ready_o)
		else $error("no-op cycle wrote counter or accepted work");

	// phase order inside the executing cycle
	a_phase_steps: assert property (
		!ready_o |=> q == $past(q) + 2'h1)
		else $error("phase did not advance by one");
	a_offset_from_word: assert property (
		state == FCB_EXEC && q == PH_Q3
		|-> off_q == word_q[OFF_HI:OFF_LO])
		else $error("offset not read from the held word");
endmodule

// ==== bench/testbench.sv ====
// self-checking bench for the conditional branch unit
`timescale 1ns/100ps
module testbench;
	import fcb_pkg::*;
	// stimulus, all given a value at time zero
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic start_i = 1'b0;
	logic [WORD_W-1:0] word_i = 16'h0000;
	logic [PC_W-1:0] addr_i = 21'h000000;
	logic carry_i = 1'b0;
	logic negative_i = 1'b0;
	// observed outputs
	logic ready_o, pc_wr_o, nop_o, done_o;
	logic [PC_W-1:0] pc_target_o;
	logic [1:0] phase_o;
	// score counters
	int bad_count = 0;
	int comparisons = 0;

	// 50 MHz core clock
	always #10 clock_i = ~clock_i;

	fcb_exec u_fcb_exec (.clock_i(clock_i), .nrst_i(nrst_i),
		.start_i(start_i), .word_i(word_i), .addr_i(addr_i),
		.ready_o(ready_o), .carry_i(carry_i), .negative_i(negative_i),
		.pc_wr_o(pc_wr_o), .pc_target_o(pc_target_o),
		.phase_o(phase_o), .nop_o(nop_o), .done_o(done_o));

	// compare one value, four-state exact
	task check(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one instruction; flags flip after decode and a start is tried
	// while busy, so late flag reads or a lost refusal both show
	task run(input logic [15:0] w, input logic [20:0] a, input logic c,
		input logic n, input logic tk);
		logic [20:0] exp;
		exp = a + 21'h000002 + {{12{w[7]}}, w[7:0], 1'b0};
		@(posedge clock_i);
		start_i <= 1'b1;
		word_i <= w;
		addr_i <= a;
		carry_i <= c;
		negative_i <= n;
		@(posedge clock_i);
		start_i <= 1'b0;
		@(negedge clock_i);
		check(ready_o, 1'b0);
		check(phase_o, PH_Q1);
		@(posedge clock_i);
		carry_i <= ~c;
		negative_i <= ~n;
		start_i <= 1'b1;
		word_i <= ~w;
		@(posedge clock_i);
		start_i <= 1'b0;
		@(negedge clock_i);
		check(phase_o, PH_Q3);
		@(negedge clock_i);
		check(pc_wr_o, tk);
		check(pc_target_o, exp);
		check(done_o, !tk);
		if (tk) begin
			repeat (4) @(negedge clock_i);
			check(nop_o, 1'b1);
			check(done_o, 1'b1);
			check(phase_o, PH_Q4);
		end
		@(negedge clock_i);
		check(ready_o, 1'b1);
	endtask

	// outputs while reset is held, then release
	task test_reset;
		check(ready_o, 1'b1);
		check(pc_wr_o, 1'b0);
		check(pc_target_o, PC_RST);
		check(phase_o, PH_Q1);
		check(nop_o | done_o, 1'b0);
		@(posedge clock_i);
		nrst_i <= 1'b1;
		$display("test_reset done");
	endtask

	// carry-clear branch taken then not, negative flag opposite to carry to show it is ignored
	task test_carry;
		run(16'he3fe, 21'h000100, 1'b0, 1'b1, 1'b1);
		run(16'he3fe, 21'h000100, 1'b1, 1'b0, 1'b0);
		$display("test_carry done");
	endtask

	// negative-clear branch taken then not, carry opposite to negative to show it is ignored
	task test_sign;
		run(16'he77f, 21'h000200, 1'b1, 1'b0, 1'b1);
		run(16'he77f, 21'h000200, 1'b0, 1'b1, 1'b0);
		$display("test_sign done");
	endtask

	// extreme offsets with counter wraparound, then a sign-clear offset of one
	task test_offsets;
		run(16'he380, 21'h000000, 1'b0, 1'b0, 1'b1);
		run(16'he37f, 21'h1ffffe, 1'b0, 1'b0, 1'b1);
		run(16'he701, 21'h0abcd0, 1'b0, 1'b0, 1'b1);
		$display("test_offsets done");
	endtask

	// neighbouring opcodes must never jump
	task test_other;
		run(16'he580, 21'h000300, 1'b0, 1'b0, 1'b0);
		run(16'he6ff, 21'h000302, 1'b0, 1'b0, 1'b0);
		$display("test_other done");
	endtask

	// reset pulled in mid-branch, then a zero offset jump runs clean
	task test_midreset;
		@(posedge clock_i);
		start_i <= 1'b1;
		word_i <= 16'he310;
		addr_i <= 21'h000500;
		carry_i <= 1'b0;
		@(posedge clock_i);
		start_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		nrst_i <= 1'b0;
		@(negedge clock_i);
		check(ready_o, 1'b1);
		check(pc_wr_o, 1'b0);
		check(pc_target_o, PC_RST);
		check(phase_o, PH_Q1);
		check(nop_o | done_o, 1'b0);
		@(posedge clock_i);
		nrst_i <= 1'b1;
		run(16'he300, 21'h000400, 1'b0, 1'b0, 1'b1);
		$display("test_midreset done");
	endtask

	// counts and the single closing point
	task give_verdict;
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// main sequence, reset held for 8 cycles first
	initial begin
		repeat (7) @(posedge clock_i);
		test_reset;
		test_carry;
		test_sign;
		test_offsets;
		test_other;
		test_midreset;
		give_verdict;
	end

	// watchdog, well beyond the ~100 cycles the tests need
	initial begin
		repeat (2000) @(posedge clock_i);
		bad_count++;
		give_verdict;
	end
endmodule
